// >>> logic/lpms_seq.sv
`include "lpms_defs.svh"
// ----------------------------------------
// Low-power mode sequencer
// ----------------------------------------
module lpms_seq #(
  parameter int LOCK_CYCLES = `LPMS_LOCK_CYC,
  parameter int QW          = `LPMS_QUAL_W
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rst_n,
  input  wire logic          i_idle_exec,
  input  wire logic          i_mode_halt,
  input  wire logic          i_wake_pin,
  input  wire logic          i_qual_en,
  input  wire logic [QW-1:0] i_standby_qual_count,
  input  wire logic          i_flash_asleep,
  input  wire logic          i_xtal_src,
  input  wire logic          i_wake_int_en,
  output logic               o_sysclk_en,
  output logic               o_ext_clk_out_en,
  output logic               o_periph_clk_en,
  output logic               o_pll_en,
  output logic               o_wdog_clk_en,
  output logic               o_osc_en,
  output logic               o_int_osc_en,
  output logic               o_core_clk_en,
  output logic               o_resume,
  output logic               o_wake_int,
  output logic [2:0]         o_state
);
  localparam int CW = `LPMS_CNT_W;

  lpms_pkg::lpms_state_e state_r;
  lpms_pkg::lpms_state_e state_nxt;
  logic [CW-1:0]         cnt_r;
  logic                  halt_path_r;
  logic                  wake_low_seen_r;
  logic                  qual_wake;
  logic                  cnt_done;

  // Resume latency after standby wake or halt PLL lock, in cycles
  function automatic logic [CW-1:0] resume_lat(input logic halt_path, input logic flash_asleep);
    logic [CW-1:0] lat;
    lat = '0;
    if (halt_path) begin
      lat = flash_asleep ? CW'(`LPMS_HALT_SLOW_CYC) : CW'(`LPMS_HALT_RAM_CYC);
    end else begin
      lat = flash_asleep ? CW'(`LPMS_STBY_SLOW_CYC) : CW'(`LPMS_STBY_FAST_CYC);
    end
    return lat;
  endfunction

  // ----------------------------------------
  // Standby wake qualification
  // ----------------------------------------
  lpms_wake_qual #(
    .QW (QW)
  ) lpms_wake_qual_i (
    .i_mclk       (i_mclk),
    .i_rst_n      (i_rst_n),
    .i_arm        (state_r == lpms_pkg::LPMS_STANDBY),
    .i_wake_pin   (i_wake_pin),
    .i_qual_en    (i_qual_en),
    .i_qual_count (i_standby_qual_count),
    .o_wake       (qual_wake)
  );

  // Terminal count of the current timed state
  always_comb begin
    case (state_r)
      lpms_pkg::LPMS_FLUSH:    cnt_done = (cnt_r == CW'(`LPMS_FLUSH_CYC - 1));
      lpms_pkg::LPMS_PLL_LOCK: cnt_done = (cnt_r == CW'(LOCK_CYCLES - 1));
      lpms_pkg::LPMS_RESUME:   cnt_done = (cnt_r == resume_lat(halt_path_r, i_flash_asleep) - CW'(1));
      default:                 cnt_done = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lpms_pkg::LPMS_RUN: begin
        if (i_idle_exec) begin
          state_nxt = lpms_pkg::LPMS_FLUSH;
        end
      end
      lpms_pkg::LPMS_FLUSH: begin
        if (cnt_done) begin
          state_nxt = halt_path_r ? lpms_pkg::LPMS_HALT : lpms_pkg::LPMS_STANDBY;
        end
      end
      lpms_pkg::LPMS_STANDBY: begin
        if (qual_wake) begin
          state_nxt = lpms_pkg::LPMS_RESUME;
        end
      end
      lpms_pkg::LPMS_HALT: begin
        if (!i_wake_pin) begin
          state_nxt = lpms_pkg::LPMS_OSC_WAKE;
        end
      end
      lpms_pkg::LPMS_OSC_WAKE: begin
        // Oscillator settles while the wake source holds the pin low
        if (i_wake_pin && wake_low_seen_r) begin
          state_nxt = lpms_pkg::LPMS_PLL_LOCK;
        end
      end
      lpms_pkg::LPMS_PLL_LOCK: begin
        if (cnt_done) begin
          state_nxt = lpms_pkg::LPMS_RESUME;
        end
      end
      lpms_pkg::LPMS_RESUME: begin
        if (cnt_done) begin
          state_nxt = lpms_pkg::LPMS_RUN;
        end
      end
      default: state_nxt = lpms_pkg::LPMS_RUN;
    endcase
  end

  // State register; reset pin also serves as a wake from either mode
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= lpms_pkg::LPMS_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Cycle counter restarts on every state change
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      cnt_r <= '0;
    end else if (state_r == lpms_pkg::LPMS_FLUSH || state_r == lpms_pkg::LPMS_PLL_LOCK
                 || state_r == lpms_pkg::LPMS_RESUME) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // Mode chosen when the idle instruction runs
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      halt_path_r <= 1'b0;
    end else if (state_r == lpms_pkg::LPMS_RUN && i_idle_exec) begin
      halt_path_r <= i_mode_halt;
    end
  end

  // A release only counts after the pin was seen low in the wake state
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_low_seen_r <= 1'b0;
    end else if (state_r != lpms_pkg::LPMS_OSC_WAKE) begin
      wake_low_seen_r <= 1'b0;
    end else if (!i_wake_pin) begin
      wake_low_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Clock and power controls
  // ----------------------------------------
  // System and external clocks run through the flush, then stop
  assign o_sysclk_en      = (state_r == lpms_pkg::LPMS_RUN) || (state_r == lpms_pkg::LPMS_FLUSH)
                            || (state_r == lpms_pkg::LPMS_RESUME);
  assign o_ext_clk_out_en = o_sysclk_en;
  assign o_periph_clk_en  = o_sysclk_en;
  // PLL stays up in standby, down from halt until the lock sequence starts
  assign o_pll_en         = !(state_r == lpms_pkg::LPMS_HALT || state_r == lpms_pkg::LPMS_OSC_WAKE);
  assign o_wdog_clk_en    = !(state_r == lpms_pkg::LPMS_HALT);
  // Pin low restarts the oscillator without waiting for a clock edge
  assign o_osc_en         = (state_r != lpms_pkg::LPMS_HALT) || !i_wake_pin;
  assign o_int_osc_en     = o_osc_en || !i_xtal_src;
  assign o_core_clk_en    = o_sysclk_en;
  assign o_state          = state_r;

  // Resume pulse and optional wake interrupt, both registered
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_resume   <= 1'b0;
      o_wake_int <= 1'b0;
    end else begin
      o_resume   <= (state_r == lpms_pkg::LPMS_RESUME) && cnt_done;
      o_wake_int <= (state_r == lpms_pkg::LPMS_RESUME) && cnt_done && i_wake_int_en;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  localparam int A_XMIN   = `LPMS_FLUSH_CYC;
  localparam int A_XMAX   = `LPMS_XCLK_MAX_CYC;
  localparam int A_SFAST  = `LPMS_STBY_FAST_CYC + 2;
  localparam int A_HRAM   = `LPMS_HALT_RAM_CYC + 1;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_idle;
    state_r == lpms_pkg::LPMS_RUN && i_idle_exec;
  endsequence

  property p_xclk_low;
    s_idle |-> ##[A_XMIN:A_XMAX] !o_ext_clk_out_en;
  endproperty
  a_xclk_low: assert property (p_xclk_low) else $error("External clock not low in window");

  property p_flush_hold;
    s_idle |-> ##1 o_sysclk_en [*8];
  endproperty
  a_flush_hold: assert property (p_flush_hold) else $error("System clock stopped during flush");

  property p_standby_clks;
    state_r == lpms_pkg::LPMS_STANDBY |-> !o_periph_clk_en && o_pll_en && o_wdog_clk_en;
  endproperty
  a_standby_clks: assert property (p_standby_clks) else $error("Standby clock gating wrong");

  sequence s_stby_wake;
    $rose(qual_wake) && !i_flash_asleep;
  endsequence

  property p_stby_resume;
    s_stby_wake |-> ##[1:A_SFAST] o_resume;
  endproperty
  a_stby_resume: assert property (p_stby_resume) else $error("Standby resume too late");

  property p_int_gate;
    o_wake_int |-> o_resume && $past(i_wake_int_en);
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("Wake interrupt while disabled");

  property p_halt_clks;
    state_r == lpms_pkg::LPMS_HALT |-> !o_periph_clk_en && !o_pll_en && !o_core_clk_en;
  endproperty
  a_halt_clks: assert property (p_halt_clks) else $error("Halt clocks not off");

  property p_xtal_off;
    state_r == lpms_pkg::LPMS_HALT && i_wake_pin && i_xtal_src |-> !o_int_osc_en && !o_osc_en;
  endproperty
  a_xtal_off: assert property (p_xtal_off) else $error("Oscillator running in halt");

  property p_osc_restart;
    state_r == lpms_pkg::LPMS_HALT && !i_wake_pin |-> o_osc_en ##1 state_r == lpms_pkg::LPMS_OSC_WAKE;
  endproperty
  a_osc_restart: assert property (p_osc_restart) else $error("Wake edge did not restart oscillator");

  property p_lock_start;
    state_r == lpms_pkg::LPMS_OSC_WAKE && i_wake_pin && wake_low_seen_r
      |-> ##1 state_r == lpms_pkg::LPMS_PLL_LOCK && o_pll_en && !o_core_clk_en;
  endproperty
  a_lock_start: assert property (p_lock_start) else $error("PLL lock did not start");

  property p_halt_resume;
    $fell(state_r == lpms_pkg::LPMS_PLL_LOCK) && !i_flash_asleep |-> ##[1:A_HRAM] o_resume;
  endproperty
  a_halt_resume: assert property (p_halt_resume) else $error("Halt resume too late");
endmodule

// >>> shared/lpms_defs.svh
`ifndef LPMS_DEFS_SVH
`define LPMS_DEFS_SVH
// Behaviour
// - After idle, external clock output goes low within 32 to 45 system cycles.
// - Standby entry keeps system clock running 32 cycles for flush, then stops it.
// - Standby gates peripheral clocks; PLL and watchdog stay running.
// - Standby resume within 100 cycles, or 1125 with flash asleep, plus qualification.
// - Resume latency ends at the instruction after idle; wake interrupt adds more.
// - After standby exit, wake interrupt is taken only when enabled.
// - Halt entry holds system clock 32 cycles, then stops oscillator and core clock.
// - Halt gates all peripheral clocks and shuts the PLL down.
// - Halt with crystal or resonator source also powers down internal oscillator.
// - In halt, wake pin falling edge restarts the oscillator asynchronously.
// - Wake pin release starts PLL lock lasting 131072 oscillator cycles.
// - After halt PLL lock, resume within 1125 cycles flash asleep, 35 from RAM.
// - Standby wake pulse qualified over 3 cycles, or qual count plus 2.

// ----------------------------------------
// Timing counts in system clock cycles; clock period in ns
// ----------------------------------------
`define LPMS_FLUSH_CYC     32
`define LPMS_XCLK_MAX_CYC  45
`define LPMS_STBY_FAST_CYC 100
`define LPMS_STBY_SLOW_CYC 1125
`define LPMS_HALT_SLOW_CYC 1125
`define LPMS_HALT_RAM_CYC  35
`define LPMS_LOCK_CYC      131072
`define LPMS_CLK_PERIOD_NS 100

// ----------------------------------------
// Wake qualification and cycle counter widths
// ----------------------------------------
`define LPMS_QUAL_PLAIN    3
`define LPMS_QUAL_EXTRA    2
`define LPMS_QUAL_W        6
`define LPMS_CNT_W         18
`endif

// >>> shared/lpms_pkg.sv
package lpms_pkg;
  // Gray codes in listed order; FLUSH to HALT, STANDBY to RESUME and RESUME to RUN change two bits
  typedef enum logic [2:0] {
    LPMS_RUN      = 3'h0,
    LPMS_FLUSH    = 3'h1,
    LPMS_STANDBY  = 3'h3,
    LPMS_HALT     = 3'h2,
    LPMS_OSC_WAKE = 3'h6,
    LPMS_PLL_LOCK = 3'h7,
    LPMS_RESUME   = 3'h5
  } lpms_state_e;
endpackage

// >>> logic/lpms_wake_qual.sv
`include "lpms_defs.svh"
// Counts consecutive low samples of the wake pin while armed
module lpms_wake_qual #(
  parameter int QW = `LPMS_QUAL_W
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rst_n,
  input  wire logic          i_arm,
  input  wire logic          i_wake_pin,
  input  wire logic          i_qual_en,
  input  wire logic [QW-1:0] i_qual_count,
  output logic               o_wake
);
  logic [QW:0] low_cnt_r;
  logic [QW:0] need;

  // Threshold: fixed plain width, or programmed count plus extra cycles
  assign need = i_qual_en ? ({1'b0, i_qual_count} + (QW+1)'(`LPMS_QUAL_EXTRA))
                          : (QW+1)'(`LPMS_QUAL_PLAIN);

  // ----------------------------------------
  // Low-run counter, saturates at threshold
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt_r <= '0;
    end else if (!i_arm || i_wake_pin) begin
      low_cnt_r <= '0; // A glitch shorter than the threshold restarts the count
    end else if (low_cnt_r < need) begin
      low_cnt_r <= low_cnt_r + (QW+1)'(1);
    end
  end

  // Registered qualified wake level
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= i_arm && !i_wake_pin && (low_cnt_r + (QW+1)'(1) >= need);
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_plain_width;
    $rose(o_wake) && !$past(i_qual_en) |-> $past(!i_wake_pin, 1) && $past(!i_wake_pin, 2)
                                           && $past(!i_wake_pin, 3);
  endproperty
  a_plain_width: assert property (p_plain_width) else $error("Wake taken on short pulse");
endmodule

// >>> verification/lpms_wake_src.sv
// ----------------------------------------
// Wake source on the far side of the wake pin
// ----------------------------------------
module lpms_wake_src #(
  parameter int OSC_ST = 4
) (
  input  wire logic i_mclk,
  output logic      o_wake_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pin has a pull-up, so a released pin reads high rather than the last value
  initial o_wake_pin = 1'b1;

  // Low for n sampled cycles, then released; standby callers pick n from the qual count, halt_wake from OSC_ST
  task automatic pulse(input int n);
    o_wake_pin = 1'b0;
    repeat (n) @(negedge i_mclk);
    o_wake_pin = 1'b1;
  endtask

  // Halt wake holds the pin through oscillator start-up plus 2 cycles
  task automatic halt_wake();
    pulse(OSC_ST + 2);
  endtask
endmodule

// >>> verification/lpms_seq_test.sv
module lpms_seq_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOCK = 16; // Short lock count keeps the run brief
  localparam int OSC_ST = 4; // Oscillator start-up of the model, in cycles
  logic i_mclk = 1'b0, i_rst_n = 1'b0, idle = 1'b0, mode = 1'b0;
  logic qen = 1'b0, fa = 1'b0, xt = 1'b0, ien = 1'b0;
  logic [5:0] qc = 6'h00;
  logic wake, sys_en, ext_en, per_en, pll_en, wd_en, osc_en, iosc_en, core_en, resume, wint;
  logic [2:0] state;
  int fail_count = 0, tests_run = 0, seed, n, r;

  always #50 i_mclk = ~i_mclk;

  lpms_wake_src #(.OSC_ST(OSC_ST)) lpms_wake_src_i (.i_mclk(i_mclk), .o_wake_pin(wake));
  lpms_seq #(.LOCK_CYCLES(LOCK)) lpms_seq_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_idle_exec(idle), .i_mode_halt(mode),
    .i_wake_pin(wake), .i_qual_en(qen), .i_standby_qual_count(qc), .i_flash_asleep(fa),
    .i_xtal_src(xt), .i_wake_int_en(ien), .o_sysclk_en(sys_en), .o_ext_clk_out_en(ext_en),
    .o_periph_clk_en(per_en), .o_pll_en(pll_en), .o_wdog_clk_en(wd_en), .o_osc_en(osc_en),
    .o_int_osc_en(iosc_en), .o_core_clk_en(core_en), .o_resume(resume), .o_wake_int(wint),
    .o_state(state));

  // ----------------------------------------
  // Comparison and wait helpers
  // ----------------------------------------
  task automatic chk(input logic [2:0] got, input logic [2:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: %s got %0h want %0h", $time, m, got, exp);
    end
  endtask

  // Single-bit compare, so no control is widened on the way in
  task automatic chk1(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: %s got %0b want %0b", $time, m, got, exp);
    end
  endtask

  // Low samples needed before a standby wake is taken
  function automatic int exp_qual(input logic q, input logic [5:0] cnt);
    return q ? int'(cnt) + 2 : 3;
  endfunction

  // Resume latency limit for the mode and flash state
  function automatic int exp_lat(input logic halt, input logic f);
    if (halt)
      return f ? 1125 : 35;
    else
      return f ? 1125 : 100;
  endfunction

  task automatic rng(input int v, input int lo, input int hi, input string m);
    tests_run++;
    if (v < lo || v > hi) begin
      fail_count++;
      $display("ERROR %0t: %s count %0d outside %0d..%0d", $time, m, v, lo, hi);
    end
  endtask

  // Idle pulse, then count cycles until the clock output pin drops
  task automatic enter(input logic halt, output int c);
    @(negedge i_mclk);
    idle = 1'b1;
    mode = halt;
    @(negedge i_mclk);
    idle = 1'b0;
    c = 1;
    while (ext_en !== 1'b0 && c < 60) begin
      @(negedge i_mclk);
      c++;
    end
  endtask

  // Bounded wait for the resume pulse
  task automatic wait_resume(output int c);
    c = 0;
    while (resume !== 1'b1 && c < 2000) begin
      @(negedge i_mclk);
      c++;
    end
  endtask

  task automatic after_resume();
    chk1(wint, ien, "wake interrupt");
    @(negedge i_mclk);
    chk1(resume, 1'b0, "resume one cycle");
    chk(state, lpms_pkg::LPMS_RUN, "back to run");
    chk1(sys_en, 1'b1, "clock back on");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic do_standby(input logic f, input logic ie, input logic q, input logic [5:0] cnt);
    int nq, lat;
    fa = f;
    ien = ie;
    qen = q;
    qc = cnt;
    nq = exp_qual(q, cnt);
    lat = exp_lat(1'b0, f);
    enter(1'b0, n);
    rng(n, 32, 45, "standby entry");
    chk1(sys_en, 1'b0, "sysclk stopped");
    chk1(per_en, 1'b0, "periph gated");
    chk({1'b0, wd_en, pll_en}, 3'h3, "pll and wdog kept");
    // One sample short of the count must not wake
    lpms_wake_src_i.pulse(nq - 1);
    repeat (4) @(negedge i_mclk);
    chk(state, lpms_pkg::LPMS_STANDBY, "short pulse refused");
    fork
      lpms_wake_src_i.pulse(nq);
      wait_resume(n);
    join
    rng(n, lat, lat + nq + 3, "standby resume latency");
    after_resume();
    $display("standby test done: flash_asleep %0b qual %0b count %0d", f, q, cnt);
  endtask

  task automatic do_halt(input logic f, input logic ie, input logic x);
    int lat;
    fa = f;
    ien = ie;
    xt = x;
    lat = exp_lat(1'b1, f);
    enter(1'b1, n);
    rng(n, 32, 45, "halt entry");
    chk({1'b0, core_en, osc_en}, 3'h0, "core clock and osc off");
    chk({1'b0, per_en, pll_en}, 3'h0, "periph and pll off");
    chk1(iosc_en, !x, "internal osc power");
    fork
      lpms_wake_src_i.halt_wake();
      begin
        #1;
        chk1(osc_en, 1'b1, "osc restarts on pin low");
      end
    join
    n = 0;
    while (pll_en !== 1'b1 && n < 10) begin
      @(negedge i_mclk);
      n++;
    end
    rng(n, 0, 2, "pll lock starts on release");
    chk1(sys_en, 1'b0, "clock held during lock");
    wait_resume(n);
    rng(n, LOCK + lat - 2, LOCK + lat + 3, "halt resume latency");
    after_resume();
    $display("halt test done: flash_asleep %0b xtal %0b", f, x);
  endtask

  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic report_and_stop();
    $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run of at most about 7500 cycles
  initial begin
    #(40000 * 100);
    fail_count++;
    report_and_stop();
  end

  initial begin
    seed = 32'h4f73;
    repeat (2) @(negedge i_mclk);
    i_rst_n = 1'b1;
    do_standby(1'b0, 1'b1, 1'b0, 6'h00);
    do_standby(1'b1, 1'b0, 1'b1, 6'h3F);
    do_halt(1'b0, 1'b1, 1'b1);
    do_halt(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      if (r[0])
        do_halt(r[1], r[2], r[3]);
      else
        do_standby(r[1], r[2], r[3], {3'h0, r[6:4]});
    end
    // Reset pin wake out of halt, held start-up plus 8 cycles
    enter(1'b1, n);
    i_rst_n = 1'b0;
    #1;
    chk(state, lpms_pkg::LPMS_RUN, "reset wake state");
    repeat (OSC_ST + 8) @(negedge i_mclk);
    i_rst_n = 1'b1;
    chk({1'b0, osc_en, sys_en}, 3'h3, "clocks on after reset wake");
    $display("reset wake test done");
    report_and_stop();
  end
endmodule
